// ---- hw/lcig_top.v ----
// Purpose: input side of a configurable logic cell with register port
// Assumes: sources synchronous to core_clk_i; synchronous active-low reset
// Notes: read data valid in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "lcig_defs.vh"
module lcig_top #(
  parameter SRC_W = 8
) (
  input  wire              core_clk_i,
  input  wire              rst_n_i,
  input  wire [7:0]        addr_i,
  input  wire [31:0]       wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [31:0]       rdata_o,
  input  wire [SRC_W-1:0]  src1_cand_i,
  input  wire [SRC_W-1:0]  src2_cand_i,
  input  wire [SRC_W-1:0]  src3_cand_i,
  input  wire [SRC_W-1:0]  src4_cand_i,
  output reg  [3:0]        gate_o,
  output reg               cell_out_o,
  output reg               cell_out_en_o,
  output reg               irq_o
);
  reg  [31:0] ctrl_r;
  reg  [31:0] src_sel_r;
  reg  [31:0] gate_sel_r;
  reg  [1:0]  int_stat_r;
  reg  [1:0]  int_mask_r;
  reg  [1:0]  int_stat_nxt;
  reg  [31:0] rd_nxt;
  reg         sr_q_r;
  reg         logic_prev_r;
  reg  [3:0]  src_v;
  reg         logic_v;
  wire [3:0]  gate_raw;
  wire [3:0]  gate_pol;
  wire [2:0]  mode;
  wire        enable;

  assign enable = ctrl_r[`LCIG_CTRL_EN];
  assign mode   = ctrl_r[`LCIG_CTRL_MODE_LO+2:`LCIG_CTRL_MODE_LO];

  // each 3-bit field picks one of eight candidates
  always @* begin
    src_v[0] = src1_cand_i[src_sel_r[2:0]];   // [RL1]
    src_v[1] = src2_cand_i[src_sel_r[6:4]];   // [RL1]
    src_v[2] = src3_cand_i[src_sel_r[10:8]];  // [RL1]
    src_v[3] = src4_cand_i[src_sel_r[14:12]]; // [RL1]
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_gate
      lcig_gate u_gate (
        .src_i  (src_v),
        .en_i   (gate_sel_r[8*g+7:8*g]), // [RL6] [RL7] [RL8]
        .gate_o (gate_raw[g])
      );
      assign gate_pol[g] = gate_raw[g] ^ ctrl_r[`LCIG_CTRL_GPOL_LO+g]; // [RL10]
    end
  endgenerate

  // function select over the four gate outputs
  always @* begin
    case (mode) // [RL9]
      `LCIG_MODE_AND_OR:  logic_v = (gate_pol[0] & gate_pol[1]) | (gate_pol[2] & gate_pol[3]);
      `LCIG_MODE_OR_XOR:  logic_v = (gate_pol[0] | gate_pol[1]) ^ (gate_pol[2] | gate_pol[3]);
      `LCIG_MODE_AND4:    logic_v = &gate_pol;
      `LCIG_MODE_SR:      logic_v = sr_q_r;
      `LCIG_MODE_OR4:     logic_v = |gate_pol;
      `LCIG_MODE_XOR4:    logic_v = ^gate_pol;
      `LCIG_MODE_AND2_OR: logic_v = (gate_pol[0] & gate_pol[1]) | gate_pol[2];
      default:            logic_v = gate_pol[0];
    endcase
  end

  // set-reset latch: gates 1|2 set, 3|4 reset; reset wins to keep it defined
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sr_q_r <= 1'b0;
    end else if (gate_pol[2] | gate_pol[3]) begin
      sr_q_r <= 1'b0;
    end else if (gate_pol[0] | gate_pol[1]) begin
      sr_q_r <= 1'b1;
    end
  end

  // edge events on logic_v before output polarity; set wins over a write-one clear
  always @* begin
    int_stat_nxt = int_stat_r;
    if (wr_i && addr_i == `LCIG_OFS_INT_STAT) begin
      int_stat_nxt = int_stat_r & ~wdata_i[1:0];
    end
    if (enable && logic_v && !logic_prev_r && ctrl_r[`LCIG_CTRL_INTP]) begin
      int_stat_nxt[`LCIG_IRQ_RISE] = 1'b1;
    end
    if (enable && !logic_v && logic_prev_r && ctrl_r[`LCIG_CTRL_INTN]) begin
      int_stat_nxt[`LCIG_IRQ_FALL] = 1'b1;
    end
  end

  always @* begin
    rd_nxt = `LCIG_RST_WORD;
    if (addr_i == `LCIG_OFS_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (addr_i == `LCIG_OFS_SRC_SEL) begin
      rd_nxt = src_sel_r;
    end else if (addr_i == `LCIG_OFS_GATE_SEL) begin
      rd_nxt = gate_sel_r;
    end else if (addr_i == `LCIG_OFS_INT_STAT) begin
      rd_nxt = {30'h0000_0000, int_stat_r};
    end else if (addr_i == `LCIG_OFS_INT_MASK) begin
      rd_nxt = {30'h0000_0000, int_mask_r};
    end else if (addr_i == `LCIG_OFS_STATUS) begin
      rd_nxt = {27'h000_0000, logic_v ^ ctrl_r[`LCIG_CTRL_POL], gate_pol};
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r        <= `LCIG_RST_WORD;
      src_sel_r     <= `LCIG_RST_WORD;
      gate_sel_r    <= `LCIG_RST_WORD;
      int_mask_r    <= 2'b00;
      int_stat_r    <= 2'b00;
      logic_prev_r  <= 1'b0;
      rdata_o       <= `LCIG_RST_WORD;
      gate_o        <= 4'h0;
      cell_out_o    <= 1'b0;
      cell_out_en_o <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      if (wr_i) begin
        if (addr_i == `LCIG_OFS_CTRL) begin
          ctrl_r <= wdata_i & `LCIG_CTRL_WMASK; // [RL9] [RL10]
        end else if (addr_i == `LCIG_OFS_SRC_SEL) begin
          src_sel_r <= wdata_i & `LCIG_SRC_WMASK; // [RL1]
        end else if (addr_i == `LCIG_OFS_GATE_SEL) begin
          gate_sel_r <= wdata_i; // [RL6] [RL7] [RL8]
        end else if (addr_i == `LCIG_OFS_INT_MASK) begin
          int_mask_r <= wdata_i[1:0];
        end
      end
      int_stat_r   <= int_stat_nxt;
      logic_prev_r <= enable ? logic_v : 1'b0;
      rdata_o      <= rd_i ? rd_nxt : `LCIG_RST_WORD;
      // disabled cell holds gate_o, cell_out_o and cell_out_en_o low so downstream sees a quiet line
      gate_o        <= enable ? gate_pol : 4'h0;
      cell_out_o    <= enable ? (logic_v ^ ctrl_r[`LCIG_CTRL_POL]) : 1'b0; // [RL9]
      cell_out_en_o <= enable & ctrl_r[`LCIG_CTRL_OE]; // [RL9]
      irq_o         <= |(int_stat_nxt & int_mask_r);
    end
  end
endmodule // lcig_top
`default_nettype wire

// ---- hw/lcig_defs.vh ----
// Purpose: constants for the logic cell input gating block
// Assumes: plain register port, 32-bit words, byte addresses
// Notes: gate select bits 31:24 hold gate four (source 4 down to 1)
// How it works
// RL1: four selectors each pick one of eight sources by a software field
// RL2: each selector yields its selected signal and the complement
// RL3: each gate ORs whichever of its eight true/inverted inputs are enabled
// RL4: a true-enable bit of one adds the plain source to the OR
// RL5: an inverted-enable bit of one adds the complemented source to the OR
// RL6: gate three enables sit in bits 23:16, e.g. bit 20 source 3 inverted
// RL7: gate two enables sit in bits 15:8, source 4 first, true then inverted
// RL8: gate one enables start at bit 7 with source 4 true, pattern downward
// RL9: control holds enable, interrupt enable, output enable, polarity, function
// RL10: control can also invert each gate output, not only the final output
// RL11: a gate with no enable bits set gives zero before its polarity
`ifndef LCIG_DEFS_VH
`define LCIG_DEFS_VH
`define LCIG_OFS_CTRL      8'h00
`define LCIG_OFS_SRC_SEL   8'h04
`define LCIG_OFS_GATE_SEL  8'h08
`define LCIG_OFS_INT_STAT  8'h0c
`define LCIG_OFS_INT_MASK  8'h10
`define LCIG_OFS_STATUS    8'h14
`define LCIG_CTRL_EN       15
`define LCIG_CTRL_INTP     11
`define LCIG_CTRL_INTN     10
`define LCIG_CTRL_OE       7
`define LCIG_CTRL_POL      5
`define LCIG_CTRL_GPOL_LO  8
`define LCIG_CTRL_MODE_LO  0
`define LCIG_CTRL_WMASK    32'h0000_8fbf
`define LCIG_SRC_WMASK     32'h0000_7777
`define LCIG_RST_WORD      32'h0000_0000
`define LCIG_MODE_AND_OR   3'h0
`define LCIG_MODE_OR_XOR   3'h1
`define LCIG_MODE_AND4     3'h2
`define LCIG_MODE_SR       3'h3
`define LCIG_MODE_OR4      3'h4
`define LCIG_MODE_XOR4     3'h5
`define LCIG_MODE_AND2_OR  3'h6
`define LCIG_MODE_PASS1    3'h7
`define LCIG_IRQ_RISE      0
`define LCIG_IRQ_FALL      1
`endif

// ---- hw/lcig_gate.v ----
// Purpose: one cell input gate, OR of enabled true and inverted sources
// Assumes: enable vector holds source 4 true at bit 7 down to source 1 inverted at bit 0
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module lcig_gate (
  input  wire [3:0] src_i,
  input  wire [7:0] en_i,
  output wire       gate_o
);
  wire [7:0] pairs;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_pair
      assign pairs[2*k+1] = src_i[k];  // [RL2]
      assign pairs[2*k]   = ~src_i[k]; // [RL2]
    end
  endgenerate
  // all enables zero leaves the OR empty, so zero [RL11]
  assign gate_o = |(pairs & en_i); // [RL3] [RL4] [RL5]
endmodule // lcig_gate
`default_nettype wire

// ---- test/lcig_src_model.sv ----
// Purpose: peripheral signals feeding the four source selectors
// Assumes: candidate pick carries level lvl_i, all other candidates its inverse
// Notes: a wrong selection shows the inverse, so it cannot match by chance
`timescale 1ns/1ps
`default_nettype none
module lcig_src_model (
  input  wire logic [3:0]  lvl_i,
  input  wire logic [2:0]  pick_i,
  output logic      [31:0] src_o
);
  for (genvar s = 0; s < 4; s++) begin : g_src
    assign src_o[8*s +: 8] = {8{~lvl_i[s]}} ^ (8'h01 << pick_i);
  end
endmodule // lcig_src_model
`default_nettype wire

// ---- test/lcig_top_asserts.sv ----
// Purpose: port checks for the logic cell input gating block
// Assumes: shadows of control, gate select and mask track the writes
// Notes: registered outputs follow their cause one edge later
`timescale 1ns/1ps
`default_nettype none
`include "lcig_defs.vh"
module lcig_top_asserts (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [3:0]  gate_o,
  input wire logic        cell_out_o,
  input wire logic        cell_out_en_o,
  input wire logic        irq_o
);
  logic [31:0] ctl_r;
  logic [7:0]  gs_r;
  logic [1:0]  msk_r;
  logic        oe_w;
  assign oe_w = ctl_r[15] & ctl_r[7];
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctl_r <= '0;
      gs_r  <= '0;
      msk_r <= '0;
    end else if (wr_i) begin
      if (addr_i == `LCIG_OFS_CTRL) ctl_r <= wdata_i & `LCIG_CTRL_WMASK;
      if (addr_i == `LCIG_OFS_GATE_SEL) gs_r <= wdata_i[7:0];
      if (addr_i == `LCIG_OFS_INT_MASK) msk_r <= wdata_i[1:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  AST_CTRL_RB: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == $past(ctl_r))
    else $error("control read back differs");
  AST_OE: assert property (oe_w == $past(oe_w) |-> cell_out_en_o == oe_w)
    else $error("output enable not enable and oe");
  AST_DIS: assert property (!ctl_r[15] && !$past(ctl_r[15]) |-> gate_o == 4'h0)
    else $error("gate output while disabled");
  AST_EMPTY: assert property (gs_r == 0 && $past(gs_r) == 0 && !$past(ctl_r[8]) |-> !gate_o[0])
    else $error("empty gate not zero");
  AST_FULL: assert property ($past(gs_r) == 8'hff && $past(ctl_r[15]) && !$past(ctl_r[8])
    |-> gate_o[0])
    else $error("full gate not one");
  AST_GPOL: assert property ($past(gs_r) == 0 && $past(ctl_r[15]) && $past(ctl_r[8])
    |-> gate_o[0])
    else $error("gate polarity not applied");
  AST_MASK: assert property (msk_r == 0 && $past(msk_r) == 0 |-> !irq_o)
    else $error("interrupt while masked");
  cover property (irq_o);
  cover property ($rose(gate_o[0]));
  cover property (rd_i && addr_i == `LCIG_OFS_GATE_SEL);
endmodule // lcig_top_asserts
bind lcig_top lcig_top_asserts u_lcig_top_asserts (.*);
`default_nettype wire

// ---- test/logic_cell_input_gating_test.sv ----
// Purpose: register-level test of the logic cell input gating block
// Assumes: strobes last one cycle; outputs settle three edges after a write
// Notes: each gate gets a different enable bit so bit positions are told apart
`timescale 1ns/1ps
`default_nettype none
`include "lcig_defs.vh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module logic_cell_input_gating_test;
  logic        core_clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0]  addr_i = 0, src1_cand_i, src2_cand_i, src3_cand_i, src4_cand_i;
  logic [31:0] wdata_i = 0, rdata_o, gw;
  logic [3:0]  gate_o, lvl = 0, lv, exp_g;
  logic [2:0]  pick = 0;
  logic        cell_out_o, cell_out_en_o, irq_o;
  int          failures = 0, n_tests = 0, j, b, g, k;
  always #10 core_clk_i = ~core_clk_i;
  lcig_src_model u_lcig_src_model (.lvl_i(lvl), .pick_i(pick),
    .src_o({src4_cand_i, src3_cand_i, src2_cand_i, src1_cand_i}));
  lcig_top u_lcig_top (.*);
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 `CHK("rdata", e, rdata_o)
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(`LCIG_OFS_GATE_SEL, 32'h0000_0000);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8000);
    for (j = 0; j < 8; j++) begin
      pick <= j[2:0];
      wr_reg(`LCIG_OFS_SRC_SEL, 32'h0000_1111 * j);
      for (b = 0; b < 8; b++) begin
        lv = 4'(j * 3 + b);
        lvl <= lv;
        gw = '0;
        for (g = 0; g < 4; g++) begin
          k = (b + g) % 8;
          gw[8 * g + k] = 1'b1;
          exp_g[g] = lv[k / 2] ^ ~k[0];
        end
        wr_reg(`LCIG_OFS_GATE_SEL, gw);
        settle();
        `CHK("gate", exp_g, gate_o)
      end
    end
    wr_reg(`LCIG_OFS_GATE_SEL, 32'hffff_ffff);
    settle();
    `CHK("gate all", 4'hf, gate_o)
    rd_chk(`LCIG_OFS_GATE_SEL, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_0000);
    wr_reg(`LCIG_OFS_GATE_SEL, 32'h0000_0000);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8080);
    settle();
    `CHK("gate none", 4'h0, gate_o)
    `CHK("out en", 1'b1, cell_out_en_o)
    rd_chk(`LCIG_OFS_CTRL, 32'h0000_8080);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8807);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8907);
    settle();
    `CHK("gate pol", 4'h9, gate_o)
    `CHK("cell out", 1'b1, cell_out_o)
    `CHK("irq masked", 1'b0, irq_o)
    rd_chk(`LCIG_OFS_INT_STAT, 32'h0000_0001);
    wr_reg(`LCIG_OFS_INT_MASK, 32'h0000_0001);
    settle();
    `CHK("irq", 1'b1, irq_o)
    wr_reg(`LCIG_OFS_INT_STAT, 32'h0000_0001);
    settle();
    `CHK("irq clr", 1'b0, irq_o)
    rd_chk(`LCIG_OFS_STATUS, 32'h0000_0019);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8d03);
    settle();
    `CHK("sr reset wins", 1'b0, cell_out_o)
    rd_chk(`LCIG_OFS_INT_STAT, 32'h0000_0002);
    wr_reg(`LCIG_OFS_CTRL, 32'h0000_8124);
    settle();
    `CHK("or4 inverted out", 1'b0, cell_out_o)
    rd_chk(`LCIG_OFS_STATUS, 32'h0000_0001);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    give_verdict();
  end
endmodule // logic_cell_input_gating_test
`default_nettype wire
